// ==== hw/hcsc_pkg.sv ====
// package: constants, register map and types of the hub clock and strap block
package hcsc_pkg;

  // system clock
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;

  // clock plan of the hub core
  localparam int XTAL_MHZ = 6;
  localparam int CORE_CLK_MHZ = 48;
  localparam int BIT_CLK_MHZ = 12;
  localparam int BIT_DIV = CORE_CLK_MHZ / BIT_CLK_MHZ;
  localparam logic [3:0] PLL_MULT = 4'(CORE_CLK_MHZ / XTAL_MHZ);

  // overcurrent filter: least time, rounded up to whole cycles
  localparam int OC_FILTER_NS = 1000;
  localparam int OC_FILTER_CYC = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;

  // cycles spent in the settle state before straps are captured
  localparam int SETTLE_CYC = 4;

  localparam int NPORTS = 4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_OC_CLR = 8'h0C;

  // reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] EE_RST = 3'h0;

  // eeprom register fields
  localparam int EE_SCK_BIT = 0;
  localparam int EE_SDA_OUT_BIT = 1;
  localparam int EE_SDA_OE_BIT = 2;
  localparam int EE_SDA_IN_BIT = 3;

  // status register fields
  localparam int ST_CLK_DIRECT = 0;
  localparam int ST_BUS_PWR = 1;
  localparam int ST_EE_DIS = 2;
  localparam int ST_GANG = 3;
  localparam int ST_RUN = 4;
  localparam int ST_OC_LSB = 8;
  localparam int ST_LATCH_LSB = 12;

  // decoded strap settings, held from capture until next reset
  typedef struct packed {
    logic clk_direct;
    logic bus_powered;
    logic ee_disable;
    logic ganged;
  } hcsc_cfg_t;

  // software-driven eeprom pin controls
  typedef struct packed {
    logic sda_oe;
    logic sda_out;
    logic sck;
  } hcsc_ee_t;

  // strap capture sequence, gray along the path
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SETTLE = 2'b01,
    S_RUN = 2'b11
  } hcsc_state_t;

endpackage : hcsc_pkg

// ==== hw/hcsc_oc_filter.sv ====
// overcurrent noise filter: output follows input only after it stands still
`timescale 1ns/1ns
`default_nettype none
module hcsc_oc_filter
  import hcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic level_i,
  output logic filt_o
);

  logic [7:0] cnt_q; // cycles the input has differed from the output
  logic [7:0] cnt_d;
  logic filt_q;
  logic filt_d;

  ////////////////////////////////////////////////////////////////////////////
  // a spike shorter than the filter time never reaches the output
  always_comb
  begin
    cnt_d = 8'h00;
    filt_d = filt_q;
    if (level_i != filt_q)
    begin
      if (cnt_q == 8'(OC_FILTER_CYC - 1))
        filt_d = level_i;
      else
        cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 8'h00;
      filt_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt_o = filt_q;

endmodule : hcsc_oc_filter
`default_nettype wire

// ==== hw/hcsc_top.sv ====
// top: strap capture, clock source control, eeprom pins, port power, wishbone
// Contract
// - strap low: core runs from analog pll
// - strap high: direct clock, pll off and bypassed
// - strap high: crystal oscillator stays powered down
// - crystal mode: 48 MHz core, 12 MHz bit clock
// - bus power strap high bus, low self
// - memory disable high: eeprom clock not driven
// - eeprom disabled: shared pin is gang strap
// - memory disable low: clock driven, pulldown enabled
// - memory disable low: shared pin is eeprom data
// - ganged: ports switch and trip together
// - overcurrent inputs active low and filtered
`timescale 1ns/1ns
`default_nettype none
module hcsc_top
  import hcsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic clock_source_select_i,
  input wire logic bus_power_strap_i,
  input wire logic external_memory_disable_i,
  input wire logic eeprom_data_or_gang_strap_i,
  input wire logic [NPORTS-1:0] port_overcurrent_n_i,
  output logic core_clk_sel_o,
  output logic pll_power_down_o,
  output logic pll_bypass_o,
  output logic osc_power_down_o,
  output logic [3:0] pll_mult_o,
  output logic bit_clk_en_o,
  output logic bus_powered_o,
  output logic eeprom_serial_clock_o,
  output logic eeprom_serial_clock_oe_o,
  output logic eeprom_data_o,
  output logic eeprom_data_oe_o,
  output logic eeprom_pulldown_en_o,
  output logic [NPORTS-1:0] port_power_enable_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: straps, shared data pin, overcurrent pins
  localparam int SW = 4 + NPORTS;
  logic [SW-1:0] meta_q; // first stage, read only by the second
  logic [SW-1:0] sync_q; // second stage
  logic [SW-1:0] pins_w;
  assign pins_w = {~port_overcurrent_n_i, eeprom_data_or_gang_strap_i,
                   external_memory_disable_i, bus_power_strap_i, clock_source_select_i};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pins_w;
      sync_q <= meta_q;
    end
  end

  logic [NPORTS-1:0] oc_act_w; // overcurrent, now active high
  assign oc_act_w = sync_q[SW-1:4];

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent filters, one per port
  logic [NPORTS-1:0] oc_filt_w;
  for (genvar p = 0; p < NPORTS; p++)
  begin : g_oc
    hcsc_oc_filter u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .level_i(oc_act_w[p]),
      .filt_o(oc_filt_w[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // strap capture sequence; settings frozen once captured
  hcsc_state_t state_q;
  hcsc_state_t state_d;
  logic [2:0] settle_q; // waits out the synchroniser fill
  logic [2:0] settle_d;
  hcsc_cfg_t cfg_q;
  hcsc_cfg_t cfg_d;

  always_comb
  begin
    state_d = state_q;
    settle_d = settle_q;
    cfg_d = cfg_q;
    case (state_q)
      S_IDLE: state_d = S_SETTLE;
      S_SETTLE:
      begin
        settle_d = settle_q + 3'h1;
        if (settle_q == 3'(SETTLE_CYC - 1))
        begin
          // strap changes later are ignored on purpose
          cfg_d.clk_direct = sync_q[0];
          cfg_d.bus_powered = sync_q[1];
          cfg_d.ee_disable = sync_q[2];
          cfg_d.ganged = sync_q[2] & sync_q[3];
          state_d = S_RUN;
        end
      end
      S_RUN: state_d = S_RUN;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      settle_q <= 3'h0;
      cfg_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      settle_q <= settle_d;
      cfg_q <= cfg_d;
    end
  end

  logic run_w;
  assign run_w = (state_q == S_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave registers; ack one cycle after the strobe, writes land on the ack edge
  logic [3:0] ctrl_q; // per-port power requests
  logic [3:0] ctrl_d;
  hcsc_ee_t ee_q;
  hcsc_ee_t ee_d;
  logic [NPORTS-1:0] latch_q; // sticky overcurrent trips
  logic [NPORTS-1:0] latch_d;
  logic ack_d;
  logic [31:0] dat_d;
  logic wr_w;
  logic [NPORTS-1:0] trip_w;
  assign wr_w = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];

  // ganged mode lets any filtered trip kill every port
  function automatic logic [NPORTS-1:0] spread(input logic gang, input logic [NPORTS-1:0] v);
    spread = gang ? {NPORTS{|v}} : v;
  endfunction : spread

  assign trip_w = run_w ? spread(cfg_q.ganged, oc_filt_w) : '0;

  always_comb
  begin
    ctrl_d = ctrl_q;
    ee_d = ee_q;
    latch_d = latch_q;
    ack_d = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    dat_d = 32'h0000_0000;
    if (wr_w && wb_adr_i == REG_CTRL)
      ctrl_d = wb_dat_i[3:0];
    else if (wr_w && wb_adr_i == REG_EE)
      ee_d = wb_dat_i[2:0];
    else if (wr_w && wb_adr_i == REG_OC_CLR)
      latch_d = latch_q & ~spread(cfg_q.ganged, wb_dat_i[NPORTS-1:0]);
    // a trip in the clearing cycle still sticks
    latch_d = latch_d | trip_w;
    if (ack_d && !wb_we_i)
    begin
      if (wb_adr_i == REG_CTRL)
        dat_d[3:0] = ctrl_q;
      else if (wb_adr_i == REG_EE)
      begin
        dat_d[2:0] = ee_q;
        dat_d[EE_SDA_IN_BIT] = sync_q[3];
      end
      else if (wb_adr_i == REG_STATUS)
      begin
        dat_d[ST_CLK_DIRECT] = cfg_q.clk_direct;
        dat_d[ST_BUS_PWR] = cfg_q.bus_powered;
        dat_d[ST_EE_DIS] = cfg_q.ee_disable;
        dat_d[ST_GANG] = cfg_q.ganged;
        dat_d[ST_RUN] = run_w;
        dat_d[ST_OC_LSB +: NPORTS] = oc_filt_w;
        dat_d[ST_LATCH_LSB +: NPORTS] = latch_q;
      end
      else if (wb_adr_i == REG_OC_CLR)
        dat_d[NPORTS-1:0] = latch_q;
      // unmapped addresses read as zero
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RST;
      ee_q <= EE_RST;
      latch_q <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ee_q <= ee_d;
      latch_q <= latch_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and clock-control outputs, all registered
  logic [1:0] bit_cnt_q; // 48 to 12 divider
  logic [1:0] bit_cnt_d;
  logic [NPORTS-1:0] pwr_req_w;
  assign pwr_req_w = cfg_q.ganged ? {NPORTS{ctrl_q[0]}} : ctrl_q;

  always_comb
  begin
    bit_cnt_d = run_w ? bit_cnt_q + 2'h1 : 2'h0;
    if (run_w && bit_cnt_q == 2'(BIT_DIV - 1))
      bit_cnt_d = 2'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bit_cnt_q <= 2'h0;
      core_clk_sel_o <= 1'b0;
      pll_power_down_o <= 1'b0;
      pll_bypass_o <= 1'b0;
      osc_power_down_o <= 1'b0;
      pll_mult_o <= PLL_MULT;
      bit_clk_en_o <= 1'b0;
      bus_powered_o <= 1'b0;
      eeprom_serial_clock_o <= 1'b0;
      eeprom_serial_clock_oe_o <= 1'b0;
      eeprom_data_o <= 1'b0;
      eeprom_data_oe_o <= 1'b0;
      eeprom_pulldown_en_o <= 1'b0;
      port_power_enable_n_o <= '1;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      core_clk_sel_o <= run_w & cfg_q.clk_direct;
      pll_power_down_o <= run_w & cfg_q.clk_direct;
      pll_bypass_o <= run_w & cfg_q.clk_direct;
      osc_power_down_o <= run_w & cfg_q.clk_direct;
      pll_mult_o <= PLL_MULT;
      bit_clk_en_o <= run_w && bit_cnt_q == 2'(BIT_DIV - 1);
      bus_powered_o <= cfg_q.bus_powered;
      eeprom_serial_clock_o <= ee_q.sck;
      eeprom_serial_clock_oe_o <= run_w & ~cfg_q.ee_disable;
      eeprom_data_o <= ee_q.sda_out;
      eeprom_data_oe_o <= run_w & ~cfg_q.ee_disable & ee_q.sda_oe;
      eeprom_pulldown_en_o <= ~(run_w & cfg_q.ee_disable);
      port_power_enable_n_o <= ~(pwr_req_w & ~latch_d & {NPORTS{run_w}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pll_path;
    run_w && !cfg_q.clk_direct |=> !core_clk_sel_o && !pll_power_down_o;
  endproperty
  a_pll_path: assert property (p_pll_path) else $error("pll path not selected");

  property p_direct_path;
    run_w && cfg_q.clk_direct |=> core_clk_sel_o && pll_power_down_o && pll_bypass_o;
  endproperty
  a_direct_path: assert property (p_direct_path) else $error("direct clock not selected");

  property p_osc_off;
    run_w |=> osc_power_down_o == $past(cfg_q.clk_direct);
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator power wrong");

  property p_bit_en;
    bit_clk_en_o |=> !bit_clk_en_o [*3] ##1 bit_clk_en_o;
  endproperty
  a_bit_en: assert property (p_bit_en) else $error("bit clock enable not one in four");

  property p_bus_pwr;
    run_w |=> bus_powered_o == $past(cfg_q.bus_powered);
  endproperty
  a_bus_pwr: assert property (p_bus_pwr) else $error("bus power mode wrong");

  property p_ee_off;
    run_w && cfg_q.ee_disable |=> !eeprom_serial_clock_oe_o && !eeprom_data_oe_o;
  endproperty
  a_ee_off: assert property (p_ee_off) else $error("eeprom pins driven while disabled");

  property p_gang_cap;
    state_q == S_SETTLE && state_d == S_RUN
      |=> cfg_q.ganged == ($past(sync_q[2]) && $past(sync_q[3]));
  endproperty
  a_gang_cap: assert property (p_gang_cap) else $error("gang strap capture wrong");

  property p_ee_clk_on;
    run_w && !cfg_q.ee_disable |=> eeprom_serial_clock_oe_o && eeprom_pulldown_en_o;
  endproperty
  a_ee_clk_on: assert property (p_ee_clk_on) else $error("eeprom clock not driven");

  property p_ee_data;
    run_w && !cfg_q.ee_disable |=> eeprom_data_oe_o == $past(ee_q.sda_oe);
  endproperty
  a_ee_data: assert property (p_ee_data) else $error("eeprom data enable wrong");

  property p_gang_pwr;
    run_w && cfg_q.ganged |=> (&port_power_enable_n_o) || !(|port_power_enable_n_o);
  endproperty
  a_gang_pwr: assert property (p_gang_pwr) else $error("ganged ports differ");

  property p_trip_off;
    latch_q[0] |-> port_power_enable_n_o[0];
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("tripped port powered");

  property p_filter;
    $rose(oc_filt_w[0]) |-> $past(oc_act_w[0]) && $past(oc_act_w[0], 8);
  endproperty
  a_filter: assert property (p_filter) else $error("overcurrent glitch passed filter");

  property p_frozen;
    run_w && $past(run_w) |-> $stable(cfg_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("strap settings changed");

  c_direct: cover property (run_w && cfg_q.clk_direct);
  c_ee_en: cover property (run_w && !cfg_q.ee_disable && eeprom_data_oe_o);
  c_gang_trip: cover property (run_w && cfg_q.ganged && |latch_q);
  c_rd: cover property (wb_ack_o && !wb_we_i);

endmodule : hcsc_top
`default_nettype wire

// ==== test/hcsc_board.sv ====
// board strap and serial memory model for the hub clock and strap block
`timescale 1ns/1ns
`default_nettype none
module hcsc_board
  import hcsc_pkg::*;
(
  input wire logic clk_i,
  input wire hcsc_cfg_t cfg_i,
  input wire logic sda_i,
  input wire logic sda_oe_i,
  input wire logic pd_i,
  input wire logic ack_i,
  output logic clk_sel_o,
  output logic bus_pwr_o,
  output logic ee_dis_o,
  output logic shared_o
);
  logic last_q; // last level seen on the data line
  ////////////////////////////////////////////////////////////
  // straps: levels follow cfg_i, which the bench may move while the hub runs
  assign clk_sel_o = cfg_i.clk_direct;
  assign bus_pwr_o = cfg_i.bus_powered;
  assign ee_dis_o = cfg_i.ee_disable;
  ////////////////////////////////////////////////////////////
  // shared pin: gang strap, or data line with pulldown
  always_comb
  begin
    if (cfg_i.ee_disable)
      shared_o = cfg_i.ganged;
    else if (sda_oe_i)
      shared_o = sda_i;
    else if (ack_i || pd_i)
      shared_o = 1'b0;
    else
      shared_o = ~last_q; // floating: never the stale level
  end
  // remember the line for the floating case
  always_ff @(posedge clk_i)
    last_q <= shared_o;
endmodule : hcsc_board
`default_nettype wire

// ==== test/test_hcsc_top.sv ====
// self-checking bench for the hub clock and strap block
`timescale 1ns/1ns
`default_nettype none
module test_hcsc_top
  import hcsc_pkg::*;
();
  logic clk_i, rst, cyc, stb, we, ack, eck, eck_oe, eda, eda_oe, pd_en, ee_ack;
  logic csel, ppd, pbyp, opd, bclk, bpw, s_clk, s_bus, s_dis, s_sh;
  logic [7:0] adr;
  logic [3:0] sel, mult, oc_n, pwr_n;
  logic [31:0] wdat, rdat;
  hcsc_cfg_t cfg; // strap levels on the board
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////
  hcsc_top DUT (.clk_i(clk_i), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .clock_source_select_i(s_clk),
    .bus_power_strap_i(s_bus), .external_memory_disable_i(s_dis),
    .eeprom_data_or_gang_strap_i(s_sh), .port_overcurrent_n_i(oc_n),
    .core_clk_sel_o(csel), .pll_power_down_o(ppd), .pll_bypass_o(pbyp),
    .osc_power_down_o(opd), .pll_mult_o(mult), .bit_clk_en_o(bclk),
    .bus_powered_o(bpw), .eeprom_serial_clock_o(eck),
    .eeprom_serial_clock_oe_o(eck_oe), .eeprom_data_o(eda),
    .eeprom_data_oe_o(eda_oe), .eeprom_pulldown_en_o(pd_en),
    .port_power_enable_n_o(pwr_n));
  hcsc_board board (.clk_i(clk_i), .cfg_i(cfg), .sda_i(eda), .sda_oe_i(eda_oe),
    .pd_i(pd_en), .ack_i(ee_ack), .clk_sel_o(s_clk), .bus_pwr_o(s_bus),
    .ee_dis_o(s_dis), .shared_o(s_sh));
  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // hang guard: the whole run needs under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // classic single wishbone cycle, waits for ack with no fixed latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk("ack", 32'h1, 32'h0);
  endtask : wb
  // reset with new straps, then wait for the run state
  task automatic restart(input hcsc_cfg_t c);
    logic [31:0] r;
    @(posedge clk_i);
    rst <= 1'b1;
    cfg <= c;
    repeat (5) @(posedge clk_i);
    rst <= 1'b0;
    r = 32'h0;
    while (r[ST_RUN] !== 1'b1)
      wb(1'b0, REG_STATUS, 32'h0, r);
    repeat (3) @(posedge clk_i);
  endtask : restart
  task automatic hold(input logic [3:0] v, input int k);
    @(posedge clk_i);
    oc_n <= v;
    repeat (k) @(posedge clk_i);
  endtask : hold
  ////////////////////////////////////////////////////////////
  initial
  begin
    hcsc_cfg_t c;
    logic [31:0] r;
    int n;
    {rst, cyc, stb, we, ee_ack} = 5'b10000;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    oc_n = 4'hF;
    cfg = '0;
    // every strap combination
    for (int i = 0; i < 16; i++)
    begin
      c = hcsc_cfg_t'(i[3:0]);
      restart(c);
      chk("core_sel", 32'(c.clk_direct), 32'(csel));
      chk("pll_pd", 32'(c.clk_direct), 32'(ppd));
      chk("pll_byp", 32'(c.clk_direct), 32'(pbyp));
      chk("osc_pd", 32'(c.clk_direct), 32'(opd));
      chk("mult", 32'h8, 32'(mult));
      chk("bus_pwr", 32'(c.bus_powered), 32'(bpw));
      if (c.ee_disable)
        chk("eck_oe", 32'h0, 32'(eck_oe));
      wb(1'b0, REG_STATUS, 32'h0, r);
      chk("status", 32'({c.ganged & c.ee_disable, c.ee_disable, c.bus_powered,
        c.clk_direct}), r & 32'hF);
    end
    n = 0;
    repeat (40)
    begin
      @(posedge clk_i);
      n += 32'(bclk);
    end
    chk("bit_clk", 32'hA, 32'(n));
    $display("test straps done");
    // crystal mode, memory on: straps move after capture
    restart(4'h0);
    @(posedge clk_i);
    cfg.clk_direct <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("held_sel", 32'h0, 32'(csel));
    @(posedge clk_i);
    cfg.clk_direct <= 1'b0;
    wb(1'b1, REG_EE, 32'h7, r);
    repeat (4) @(posedge clk_i);
    chk("eck", 32'h1, 32'(eck));
    chk("pulldown", 32'h1, 32'(pd_en));
    chk("eda_oe", 32'h1, 32'(eda_oe));
    wb(1'b0, REG_EE, 32'h0, r);
    chk("ee_in_hi", 32'h8, r & 32'h8);
    wb(1'b1, REG_EE, 32'h0, r);
    repeat (5) @(posedge clk_i);
    wb(1'b0, REG_EE, 32'h0, r);
    chk("ee_in_pd", 32'h0, r & 32'h8);
    wb(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("test eeprom done");
    // per-port power and overcurrent
    wb(1'b1, REG_CTRL, 32'hF, r);
    hold(4'hF, 3);
    chk("pwr_on", 32'h0, 32'(pwr_n));
    hold(4'hD, 20);
    hold(4'hF, 80);
    chk("glitch", 32'h0, 32'(pwr_n));
    hold(4'hD, 80);
    chk("trip_one", 32'h2, 32'(pwr_n));
    wb(1'b0, REG_STATUS, 32'h0, r);
    chk("latch", 32'h2, (r >> ST_LATCH_LSB) & 32'hF);
    hold(4'hF, 80);
    wb(1'b1, REG_OC_CLR, 32'hF, r);
    hold(4'hF, 3);
    chk("cleared", 32'h0, 32'(pwr_n));
    $display("test per-port done");
    // ganged: one request and one trip act on all ports
    restart(4'h3);
    wb(1'b1, REG_CTRL, 32'h1, r);
    hold(4'hF, 3);
    chk("gang_on", 32'h0, 32'(pwr_n));
    hold(4'hE, 80);
    chk("gang_trip", 32'hF, 32'(pwr_n));
    $display("test ganged done");
    wrap_up();
  end
endmodule : test_hcsc_top
`default_nettype wire
